// *** dv/mstp_step_host.sv ***
// step controller model: resolution selects and step pulses
`default_nettype none
module mstp_step_host (
    input wire logic sys_clk,
    output logic step,
    output logic resolution_select_lo,
    output logic resolution_select_hi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        step = 1'b0;
        resolution_select_lo = 1'b0;
        resolution_select_hi = 1'b0;
    end
    task automatic pulse(input logic [1:0] res);
        @(posedge sys_clk);
        {resolution_select_hi, resolution_select_lo} <= res;
        // selects settle well before the rising edge
        repeat (5) @(posedge sys_clk);
        step <= 1'b1;
        repeat (25) @(posedge sys_clk);
        step <= 1'b0;
        repeat (25) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// testbench for the microstep translator
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned LOFF = 200;
    // 1 ms settle time before the first step, in 40 ns clocks
    localparam int unsigned WAKE_CYC = 25000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic step;
    logic resolution_select_lo;
    logic resolution_select_hi;
    logic [1:0] decay_level_input = 2'h0;
    logic translator_reset_n = 1'b1;
    logic [1:0] sense_trip = 2'h0;
    logic overcurrent = 1'b0;
    mstp_pkg::mstp_gate_s [1:0] gates;
    mstp_pkg::mstp_phase_s [1:0] phases;
    logic home_n;
    logic irq;
    int n_fail = 0;
    int compares = 0;
    int idx = 4;
    int n;
    logic [31:0] rd;
    logic err;
    logic [3:0] pair;
    always #20 sys_clk = ~sys_clk;
    mstp_translator #(.LATCHOFF_CYCLES(LOFF)) DUT (
        .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .step(step),
        .resolution_select_lo(resolution_select_lo),
        .resolution_select_hi(resolution_select_hi),
        .decay_level_input(decay_level_input),
        .translator_reset_n(translator_reset_n), .sense_trip(sense_trip),
        .overcurrent(overcurrent), .gates(gates), .phases(phases),
        .home_n(home_n), .irq(irq)
    );
    mstp_step_host u_host (
        .sys_clk(sys_clk), .step(step),
        .resolution_select_lo(resolution_select_lo),
        .resolution_select_hi(resolution_select_hi)
    );
    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("BAD %0t count %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // decay code expected for one phase after a step
    function automatic logic [31:0] dec(input logic [9:0] nw, input logic [9:0] od);
        if (nw >= od) return 32'h0;
        return (decay_level_input == 2'h0) ? 32'h0 : (decay_level_input == 2'h1) ? 32'h1 : 32'h2;
    endfunction
    task automatic chk_pos();
        int q;
        int m;
        q = idx % 16;
        m = (q <= 8) ? q : 16 - q;
        chk(32'(phases[0].code), 32'(mstp_pkg::DAC_TAB[m]));
        chk(32'(phases[1].code), 32'(mstp_pkg::DAC_TAB[8 - m]));
        if (m != 8) chk(32'(phases[0].pol), 32'(idx < 8 || idx > 24));
        if (m != 0) chk(32'(phases[1].pol), 32'(idx < 16));
        chk(32'(home_n), 32'(idx != 4));
    endtask
    task automatic run_len(input int b, input logic [3:0] v);
        n = 0;
        while (gates[b] == v && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic pwm_chk(input int b, input logic [3:0] m);
        logic [3:0] p;
        p = gates[b];
        sense_trip[b] <= 1'b1;
        run_len(b, p);
        #1;
        chk(32'(gates[b]), 32'(p & m));
        run_len(b, p & m);
        chk_rng(n, 39, 42);
        chk(32'(gates[b]), 32'(p));
        run_len(b, p);
        chk_rng(n, 4, 7);
        sense_trip[b] <= 1'b0;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        pair = gates[0];
        chk_pos();
        chk(32'(pair == 4'h9 || pair == 4'h6), 32'h1);
        apb(1'b0, mstp_pkg::ADDR_CFG, 32'h0);
        chk(rd, mstp_pkg::CFG_RESET);
        apb(1'b0, mstp_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h7ff, 32'h4a4);
        apb(1'b1, mstp_pkg::ADDR_STATUS, 32'h0);
        apb(1'b0, mstp_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h7ff, 32'h4a4);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // short off-time and blanking keep the pwm runs brief
        apb(1'b1, mstp_pkg::ADDR_CFG, 32'h0004_0028);
        apb(1'b0, mstp_pkg::ADDR_CFG, 32'h0);
        chk(rd, 32'h0004_0028);
        apb(1'b1, mstp_pkg::ADDR_INT_MASK, 32'h7);
        repeat (WAKE_CYC) @(posedge sys_clk);
        for (int k = 0; k < 8; k++) begin
            logic [1:0] r;
            logic [9:0] o0;
            logic [9:0] o1;
            r = 2'(k % 4);
            o0 = phases[0].code;
            o1 = phases[1].code;
            decay_level_input <= 2'(k / 2);
            u_host.pulse(r);
            idx = (idx + (8 >> r)) % 32;
            chk_pos();
            apb(1'b0, mstp_pkg::ADDR_STATUS, 32'h0);
            chk(32'(rd[4:0]), 32'(idx));
            chk(32'(rd[6:5]), dec(phases[0].code, o0));
            chk(32'(rd[8:7]), dec(phases[1].code, o1));
            if (phases[0].code != 0) chk(32'(gates[0]), 32'(pair ^ {4{~phases[0].pol}}));
        end
        pwm_chk(1, 4'h5);
        pwm_chk(0, 4'h0);
        apb(1'b1, mstp_pkg::ADDR_INT_STATUS, 32'h7);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        overcurrent <= 1'b1;
        repeat (30) @(posedge sys_clk);
        overcurrent <= 1'b0;
        apb(1'b0, mstp_pkg::ADDR_STATUS, 32'h0);
        chk(32'(rd[9]), 32'h0);
        overcurrent <= 1'b1;
        repeat (41) @(posedge sys_clk);
        overcurrent <= 1'b0;
        chk(32'(gates), 32'h0);
        apb(1'b0, mstp_pkg::ADDR_STATUS, 32'h0);
        chk(32'(rd[9]), 32'h1);
        run_len(0, 4'h0);
        chk_rng(n, 188, 200);
        apb(1'b0, mstp_pkg::ADDR_INT_STATUS, 32'h0);
        chk(rd & 32'h7, 32'h2);
        chk(32'(irq), 32'h1);
        apb(1'b1, mstp_pkg::ADDR_INT_MASK, 32'h5);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        apb(1'b1, mstp_pkg::ADDR_INT_MASK, 32'h7);
        apb(1'b1, mstp_pkg::ADDR_INT_STATUS, 32'h2);
        apb(1'b0, mstp_pkg::ADDR_INT_STATUS, 32'h0);
        chk(rd & 32'h7, 32'h0);
        translator_reset_n <= 1'b0;
        u_host.pulse(2'h3);
        idx = 4;
        chk_pos();
        chk(32'(gates), 32'h0);
        translator_reset_n <= 1'b1;
        apb(1'b0, mstp_pkg::ADDR_INT_STATUS, 32'h0);
        chk(32'(rd[2]), 32'h1);
        // falling phase 0 current picks mixed decay for the trip below
        decay_level_input <= 2'h1;
        u_host.pulse(2'h3);
        idx = 5;
        chk_pos();
        sense_trip[0] <= 1'b1;
        run_len(0, 4'h9);
        run_len(0, 4'h0);
        chk_rng(n, 19, 22);
        chk(32'(gates[0]), 32'h1);
        sense_trip[0] <= 1'b0;
        final_report();
    end
endmodule
`default_nettype wire

// *** src/mstp_pkg.sv ***
// constants, types and tables for the microstep translator
`default_nettype none
package mstp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned BLANK_NS = 950;
    localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OFF_US = 38;
    localparam int unsigned OFF_CYC = (OFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OC_BLANK_NS = 1500;
    localparam int unsigned OC_BLANK_CYC = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LATCHOFF_US = 1600;
    localparam int unsigned LATCHOFF_CYC = (LATCHOFF_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TRIP_DIV = 8;
    localparam logic [4:0] HOME_IDX = 5'h04;
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
    localparam int unsigned CFG_OFF_LSB = 0;
    localparam int unsigned CFG_BLANK_LSB = 16;
    localparam logic [31:0] CFG_RESET = 32'(BLANK_CYC << CFG_BLANK_LSB) | 32'(OFF_CYC);
    localparam int unsigned EV_STEP = 0;
    localparam int unsigned EV_FAULT = 1;
    localparam int unsigned EV_HOME = 2;
    // winding current in per mille of full-scale trip current, 0..90 degrees
    localparam logic [9:0] DAC_TAB [9] = '{10'h3e8, 10'h3d5, 10'h39c, 10'h33f, 10'h2c3,
        10'h22c, 10'h17f, 10'h0c3, 10'h000};
    typedef enum logic [1:0] {DECAY_SLOW, DECAY_MIXED, DECAY_FAST} mstp_decay_e;
    typedef enum logic [1:0] {RES_FULL, RES_HALF, RES_QUARTER, RES_EIGHTH} mstp_res_e;
    typedef enum logic [1:0] {PW_IDLE, PW_ON, PW_OFF} mstp_pwm_e;
    typedef struct packed {
        logic hs_a;
        logic ls_a;
        logic hs_b;
        logic ls_b;
    } mstp_gate_s;
    typedef struct packed {
        logic pol;
        logic [9:0] code;
    } mstp_phase_s;
endpackage
`default_nettype wire

// *** src/mstp_translator.sv ***
// step translator, decay selection, off-time pwm and overcurrent latch-off
`default_nettype none
// How it works
// (RULE1) select pins pick full, half, quarter or eighth step
// (RULE2) reset loads home dac codes, polarities and mixed decay
// (RULE3) accepted step moves both phases to next table entry
// (RULE4) lower new code takes decay from the decay-level input
// (RULE5) higher or equal new code uses slow decay
// (RULE6) on-period drives the diagonal pair chosen by polarity
// (RULE7) trip turns off high side in slow, both otherwise
// (RULE8) off-time one-shot keeps drivers off, duration configurable
// (RULE9) comparator ignored for blanking interval after switching on
// (RULE10) dac scales reference; full-scale trip is ref over eight sense
// (RULE11) overcurrent counts only after persisting past its blank time
// (RULE12) controller holds step high and low at least 1 us each
// (RULE13) confirmed fault disables every switch for 1.6 ms
// (RULE14) only step rising edge advances; selects sampled then
// (RULE15) reset pin low holds home, outputs off, steps ignored
// (RULE16) controller waits 1 ms after standby before stepping
// (RULE17) off-time expiry starts a new on-period with blanking
module mstp_translator #(
    parameter int unsigned LATCHOFF_CYCLES = mstp_pkg::LATCHOFF_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic step,
    input wire logic resolution_select_lo,
    input wire logic resolution_select_hi,
    input wire logic [1:0] decay_level_input,
    input wire logic translator_reset_n,
    input wire logic [1:0] sense_trip,
    input wire logic overcurrent,
    output mstp_pkg::mstp_gate_s [1:0] gates,
    output mstp_pkg::mstp_phase_s [1:0] phases,
    output logic home_n,
    output logic irq
);
    function automatic logic [9:0] mag(input logic [4:0] i, input logic ph);
        logic [3:0] sel;
        sel = (i[3] ^ ph) ? 4'(4'h8 - {1'b0, i[2:0]}) : {1'b0, i[2:0]};
        return mstp_pkg::DAC_TAB[sel];
    endfunction

    logic step_q_reg, step_q_next;
    logic [4:0] idx_reg, idx_next;
    mstp_pkg::mstp_decay_e [1:0] decay_reg, decay_next;
    mstp_pkg::mstp_phase_s [1:0] phase_next;
    logic home_n_next;
    logic step_rise;
    mstp_pkg::mstp_decay_e level_dec;
    logic [4:0] step_sz;
    logic [5:0] oc_cnt_reg, oc_cnt_next;
    logic [15:0] latch_cnt_reg, latch_cnt_next;
    logic fault_start;
    logic blocked;
    logic [31:0] cfg_reg, cfg_next, int_st_reg, int_st_next, int_mask_reg, int_mask_next;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next, irq_next;
    logic [2:0] ev;
    // home entry for both phases, so the first on-pair after reset already uses home polarity
    localparam mstp_pkg::mstp_phase_s HOME_PH = '{pol: 1'b1,
        code: mstp_pkg::DAC_TAB[mstp_pkg::HOME_IDX[2:0]]};

    assign step_rise = step & ~step_q_reg;
    assign blocked = ~translator_reset_n | (latch_cnt_reg != 16'h0000);
    // pin is a level band in hardware; a two-bit code stands in for it here
    assign level_dec = (decay_level_input == 2'h0) ? mstp_pkg::DECAY_SLOW :
                       (decay_level_input == 2'h1) ? mstp_pkg::DECAY_MIXED :
                       mstp_pkg::DECAY_FAST;

    // translator
    always_comb begin
        step_q_next = step;
        idx_next = idx_reg;
        decay_next = decay_reg;
        step_sz = 5'h01;
        // (RULE1) resolution decode
        case (mstp_pkg::mstp_res_e'({resolution_select_hi, resolution_select_lo}))
            mstp_pkg::RES_FULL: step_sz = 5'h08;
            mstp_pkg::RES_HALF: step_sz = 5'h04;
            mstp_pkg::RES_QUARTER: step_sz = 5'h02;
            default: step_sz = 5'h01;
        endcase
        if (!translator_reset_n) begin
            // (RULE15) hold home while pin is low
            idx_next = mstp_pkg::HOME_IDX;
            decay_next = '{mstp_pkg::DECAY_MIXED, mstp_pkg::DECAY_MIXED};
        end else if (step_rise) begin
            // (RULE14) rising edge only, selects sampled here
            // (RULE3) advance by step size
            idx_next = 5'(idx_reg + step_sz);
            for (int b = 0; b < 2; b++) begin
                // (RULE4) falling current uses decay-level input
                // (RULE5) rising or equal current uses slow decay
                decay_next[b] = (mag(idx_next, b[0]) < mag(idx_reg, b[0])) ? level_dec :
                    mstp_pkg::DECAY_SLOW;
            end
        end
        // (RULE10) code is per mille of ref/(TRIP_DIV * rsense), for the external dac
        phase_next[0] = '{pol: ~(idx_next[4] ^ idx_next[3]), code: mag(idx_next, 1'b0)};
        phase_next[1] = '{pol: ~idx_next[4], code: mag(idx_next, 1'b1)};
        home_n_next = (idx_next != mstp_pkg::HOME_IDX);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // (RULE2) home state and mixed decay
            step_q_reg <= 1'b0;
            idx_reg <= mstp_pkg::HOME_IDX;
            decay_reg <= '{mstp_pkg::DECAY_MIXED, mstp_pkg::DECAY_MIXED};
            phases <= {HOME_PH, HOME_PH};
            home_n <= 1'b0;
        end else begin
            step_q_reg <= step_q_next;
            idx_reg <= idx_next;
            decay_reg <= decay_next;
            phases <= phase_next;
            home_n <= home_n_next;
        end
    end

    // overcurrent filter and latch-off
    always_comb begin
        oc_cnt_next = overcurrent ? 6'(oc_cnt_reg + 6'h01) : 6'h00;
        latch_cnt_next = latch_cnt_reg;
        fault_start = 1'b0;
        if (latch_cnt_reg != 16'h0000) begin
            latch_cnt_next = 16'(latch_cnt_reg - 16'h0001);
            oc_cnt_next = 6'h00;
        end else if (overcurrent && oc_cnt_reg == 6'(mstp_pkg::OC_BLANK_CYC - 1)) begin
            // (RULE11) persisted past overcurrent blank time
            // (RULE13) start latch-off
            fault_start = 1'b1;
            latch_cnt_next = 16'(LATCHOFF_CYCLES);
            oc_cnt_next = 6'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oc_cnt_reg <= 6'h00;
            latch_cnt_reg <= 16'h0000;
        end else begin
            oc_cnt_reg <= oc_cnt_next;
            latch_cnt_reg <= latch_cnt_next;
        end
    end

    // per-bridge fixed off-time regulator
    mstp_pkg::mstp_pwm_e [1:0] pw_reg;
    logic [1:0][15:0] pw_cnt_reg;
    for (genvar g = 0; g < 2; g++) begin : g_bridge
        mstp_pkg::mstp_pwm_e pw_next;
        logic [15:0] cnt_next;
        mstp_pkg::mstp_gate_s on_gate, low_gate, gate_next;
        always_comb begin
            // (RULE6) diagonal pair from polarity
            on_gate = phases[g].pol ? 4'b1001 : 4'b0110;
            low_gate = phases[g].pol ? 4'b0001 : 4'b0100;
            pw_next = pw_reg[g];
            cnt_next = pw_cnt_reg[g];
            gate_next = gates[g];
            case (pw_reg[g])
                mstp_pkg::PW_IDLE: begin
                    pw_next = mstp_pkg::PW_ON;
                    cnt_next = 16'(cfg_reg[mstp_pkg::CFG_BLANK_LSB +: 8]);
                    gate_next = on_gate;
                end
                mstp_pkg::PW_ON: begin
                    gate_next = on_gate;
                    if (cnt_next != 16'h0000) begin
                        // (RULE9) comparator blanked
                        cnt_next = 16'(cnt_next - 16'h0001);
                    end else if (sense_trip[g]) begin
                        // (RULE7) latch reset, decay-dependent turn-off
                        // (RULE8) load off-time one-shot
                        pw_next = mstp_pkg::PW_OFF;
                        cnt_next = cfg_reg[mstp_pkg::CFG_OFF_LSB +: 16];
                        gate_next = (decay_reg[g] == mstp_pkg::DECAY_SLOW) ? low_gate : 4'b0000;
                    end
                end
                default: begin
                    // mixed turns slow for the second half of the off-time
                    gate_next = (decay_reg[g] == mstp_pkg::DECAY_SLOW ||
                        (decay_reg[g] == mstp_pkg::DECAY_MIXED &&
                        cnt_next <= {1'b0, cfg_reg[15:1]})) ? low_gate : 4'b0000;
                    if (cnt_next <= 16'h0001) begin
                        // (RULE17) new on-period with fresh blanking
                        pw_next = mstp_pkg::PW_ON;
                        cnt_next = 16'(cfg_reg[mstp_pkg::CFG_BLANK_LSB +: 8]);
                        gate_next = on_gate;
                    end else begin
                        cnt_next = 16'(cnt_next - 16'h0001);
                    end
                end
            endcase
            if (blocked) begin
                // (RULE13) all switches off during latch-off or reset pin
                pw_next = mstp_pkg::PW_IDLE;
                gate_next = 4'b0000;
            end
        end
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                pw_reg[g] <= mstp_pkg::PW_IDLE;
                pw_cnt_reg[g] <= 16'h0000;
                gates[g] <= 4'b0000;
            end else begin
                pw_reg[g] <= pw_next;
                pw_cnt_reg[g] <= cnt_next;
                gates[g] <= gate_next;
            end
        end
        a_diag_on: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
            pw_reg[g] == mstp_pkg::PW_ON && $past(pw_reg[g]) == mstp_pkg::PW_ON
            |-> gates[g] == (phases[g].pol ? 4'b1001 : 4'b0110) || $changed(phases[g].pol))
            else $error("on-period does not drive the diagonal pair");
        a_trip_off: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
            pw_reg[g] == mstp_pkg::PW_ON && pw_cnt_reg[g] == 16'h0000 && sense_trip[g] &&
            !blocked |=> pw_reg[g] == mstp_pkg::PW_OFF && !gates[g].hs_a && !gates[g].hs_b)
            else $error("trip did not switch high sides off");
        a_blank_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
            pw_reg[g] == mstp_pkg::PW_ON && pw_cnt_reg[g] != 16'h0000 && !blocked
            |=> pw_reg[g] == mstp_pkg::PW_ON)
            else $error("comparator acted during blanking");
        c_trip: cover property (@(posedge sys_clk) disable iff (rst)
            pw_reg[g] == mstp_pkg::PW_OFF ##1 pw_reg[g] == mstp_pkg::PW_ON);
    end

    // apb slave, one wait-free access phase, irq status
    always_comb begin
        cfg_next = cfg_reg;
        int_mask_next = int_mask_reg;
        ev = '0;
        ev[mstp_pkg::EV_STEP] = step_rise & translator_reset_n;
        ev[mstp_pkg::EV_FAULT] = fault_start;
        ev[mstp_pkg::EV_HOME] = ~home_n_next & home_n;
        int_st_next = int_st_reg;
        pready_next = psel & ~penable;
        pslverr_next = 1'b0;
        prdata_next = prdata;
        if (psel && !penable) begin
            prdata_next = 32'h0000_0000;
            if (paddr == mstp_pkg::ADDR_CFG) begin
                prdata_next = cfg_reg;
            end else if (paddr == mstp_pkg::ADDR_STATUS) begin
                prdata_next = {21'h0, ~home_n, latch_cnt_reg != 16'h0000, decay_reg, idx_reg};
            end else if (paddr == mstp_pkg::ADDR_INT_STATUS) begin
                prdata_next = int_st_reg;
            end else if (paddr == mstp_pkg::ADDR_INT_MASK) begin
                prdata_next = int_mask_reg;
            end else begin
                pslverr_next = 1'b1;
            end
        end
        if (psel && penable && pready && pwrite) begin
            if (paddr == mstp_pkg::ADDR_CFG) begin
                cfg_next = {8'h00, pwdata[23:0]};
            end else if (paddr == mstp_pkg::ADDR_INT_STATUS) begin
                int_st_next = int_st_reg & ~pwdata;
            end else if (paddr == mstp_pkg::ADDR_INT_MASK) begin
                int_mask_next = {29'h0, pwdata[2:0]};
            end
        end
        // set wins over a same-cycle clear
        int_st_next = int_st_next | {29'h0, ev};
        irq_next = |(int_st_next & int_mask_next);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_reg <= mstp_pkg::CFG_RESET;
            int_st_reg <= '0;
            int_mask_reg <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            int_st_reg <= int_st_next;
            int_mask_reg <= int_mask_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            irq <= irq_next;
        end
    end

    localparam int OC_M1 = mstp_pkg::OC_BLANK_CYC - 1;
    a_home_reset: assert property (@(posedge sys_clk) // RULE2
        rst |=> idx_reg == mstp_pkg::HOME_IDX && decay_reg[0] == mstp_pkg::DECAY_MIXED &&
        decay_reg[1] == mstp_pkg::DECAY_MIXED) else $error("reset missed home state");
    a_full_step: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
        step_rise && translator_reset_n && !resolution_select_hi && !resolution_select_lo
        |=> idx_reg == 5'($past(idx_reg) + 5'h08)) else $error("full step size wrong");
    a_eighth_step: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
        step_rise && translator_reset_n && resolution_select_hi && resolution_select_lo
        |=> idx_reg == 5'($past(idx_reg) + 5'h01)) else $error("eighth step size wrong");
    a_no_advance: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
        !step_rise && translator_reset_n |=> $stable(idx_reg))
        else $error("translator moved without a rising step");
    a_decay_lower: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
        step_rise && translator_reset_n && mag(5'(idx_reg + step_sz), 1'b0) < mag(idx_reg, 1'b0)
        |=> decay_reg[0] == $past(level_dec)) else $error("falling current decay wrong");
    a_decay_slow: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
        step_rise && translator_reset_n && mag(5'(idx_reg + step_sz), 1'b1) >= mag(idx_reg, 1'b1)
        |=> decay_reg[1] == mstp_pkg::DECAY_SLOW) else $error("rising current not slow");
    a_oc_confirm: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
        $rose(latch_cnt_reg != 16'h0000) |-> $past(oc_cnt_reg) == 6'(OC_M1))
        else $error("fault confirmed before blank time");
    a_latch_off: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
        $past(latch_cnt_reg != 16'h0000) |-> gates == '0) else $error("switch on in latch-off");
    a_pin_reset: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
        !translator_reset_n |=> idx_reg == mstp_pkg::HOME_IDX && gates == '0)
        else $error("reset pin did not hold home");
    c_full: cover property (@(posedge sys_clk) disable iff (rst)
        step_rise && !resolution_select_hi && !resolution_select_lo);
    c_fault: cover property (@(posedge sys_clk) disable iff (rst) fault_start);
    c_irq: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
endmodule
`default_nettype wire
